// ==== rtl/psq_sequencer.sv ====
// Program sequencer: instruction timing, program counter, table reads, return stack use
// and the data space that the sequencer owns.
// Assumes an outside decoder answers each executed word with a command in the same cycle,
// and interrupt request lines already combine flag, enable and master enable.
`timescale 1ns/1ps
`include "psq_regs.svh"

module psq_sequencer (
  input wire logic clk_sys,
  input wire logic rst,
  output logic [3:0] phase_q,
  output psq_pkg::psq_pc_t pmemAddr_q,
  input wire logic [`PSQ_WORD_W-1:0] pmemData,
  output logic [`PSQ_WORD_W-1:0] instrWord_q,
  output logic execValid_q,
  input wire psq_pkg::psq_cmd_s cmd,
  input wire psq_pkg::psq_dacc_s dacc,
  output logic [7:0] rdata_q,
  input wire logic [7:0] extRdata,
  output psq_pkg::psq_dacc_s extWr_q,
  input wire logic [2:0] intReq,
  output logic [2:0] intAck_q,
  output logic stackFull_q
);
  import psq_pkg::*;

  psq_state_e state_q;
  psq_state_e state_d;
  logic [1:0] phaseCnt_q;
  psq_pc_t pc_q;
  psq_pc_t pc_d;
  logic [7:0] tblPtr_q;
  logic [7:0] tblHigh_q;
  logic [7:0] mp0_q;
  logic [7:0] mp1_q;
  logic [7:0] tabDest_q;
  logic tabLast_q;
  logic [7:0] ram [0:`PSQ_RAM_WORDS-1];
  logic endCycle;
  psq_op_e op;
  logic [7:0] daccEff;
  logic pclWrite;
  logic push;
  logic pop;
  psq_pc_t stackTop;
  logic stackFull;
  logic intTake;
  logic [2:0] intSel;
  psq_pc_t intVec;
  psq_pc_t tabAddr;
  logic wrEn;
  logic [7:0] wrAddr;
  logic [7:0] wrData;

  // Indirect locations map through a pointer; a pointer naming one of them yields itself
  function automatic logic [7:0] resolveAddr(input logic [7:0] a, input logic [7:0] p0,
                                             input logic [7:0] p1);
    if (a == `PSQ_ADDR_IND0) begin
      resolveAddr = p0;
    end else if (a == `PSQ_ADDR_IND1) begin
      resolveAddr = p1;
    end else begin
      resolveAddr = a;
    end
  endfunction

  function automatic logic isIndirect(input logic [7:0] a);
    isIndirect = (a == `PSQ_ADDR_IND0) || (a == `PSQ_ADDR_IND1);
  endfunction

  // Special registers implemented elsewhere in the core
  function automatic logic isExtSfr(input logic [7:0] a);
    isExtSfr = (a == 8'h05) || (a >= 8'h09 && a <= 8'h0b) || (a >= 8'h0d && a <= 8'h19)
               || (a == 8'h1e) || (a == 8'h1f);
  endfunction

  function automatic logic isRam(input logic [7:0] a);
    isRam = (a >= `PSQ_RAM_BASE);
  endfunction

  assign endCycle = (phaseCnt_q == `PSQ_PHASES);
  // Dummy and table cycles never execute a command
  assign op = execValid_q ? cmd.op : OP_NONE;
  assign daccEff = resolveAddr(dacc.addr, mp0_q, mp1_q);
  assign pclWrite = execValid_q && dacc.wr && !isIndirect(daccEff)
                    && (daccEff == `PSQ_ADDR_CNT_LOW);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      phaseCnt_q <= 2'h0;
      phase_q <= 4'h1;
    end else begin
      phaseCnt_q <= phaseCnt_q + 2'h1;
      phase_q <= {phase_q[2:0], phase_q[3]};
    end
  end

  // Fixed priority: external, then timer zero, then timer one
  always_comb begin
    intSel = 3'h0;
    intVec = `PSQ_VEC_EXT;
    if (intReq[0]) begin
      intSel = 3'h1;
      intVec = `PSQ_VEC_EXT;
    end else if (intReq[1]) begin
      intSel = 3'h2;
      intVec = `PSQ_VEC_TMR0;
    end else if (intReq[2]) begin
      intSel = 3'h4;
      intVec = `PSQ_VEC_TMR1;
    end
  end

  // Requests stay pending outside; vector entry, push and acknowledge all wait while the stack is full
  assign intTake = endCycle && (state_q != ST_TABLE) && (intSel != 3'h0) && !stackFull
                   && !pclWrite && (op == OP_NONE);
  // A skip would otherwise leave the discarded word as the return point

  always_comb begin
    state_d = ST_EXEC;
    pc_d = pc_q + 12'h001;
    push = 1'b0;
    pop = 1'b0;
    if (state_q == ST_TABLE) begin
      // Table fetch borrowed the bus, so the counter holds
      pc_d = pc_q;
    end else if (pclWrite) begin
      pc_d = {pc_q[11:8], dacc.wdata};
      state_d = ST_DUMMY;
    end else begin
      case (op)
        OP_JUMP: begin
          pc_d = cmd.target;
          state_d = ST_DUMMY;
        end
        OP_CALL: begin
          push = endCycle;
          pc_d = cmd.target;
          state_d = ST_DUMMY;
        end
        OP_RET, OP_RETURN_FROM_INTERRUPT: begin
          pop = endCycle;
          pc_d = stackTop;
          state_d = ST_DUMMY;
        end
        OP_SKIP: begin
          // Word already fetched at plus one is thrown away
          state_d = ST_DUMMY;
        end
        OP_TAB_CUR, OP_TAB_LAST: begin
          state_d = ST_TABLE;
        end
        default: begin
          state_d = ST_EXEC;
        end
      endcase
      if (intTake) begin
        // Discarded fetch address is the return point
        push = 1'b1;
        pc_d = intVec;
        state_d = ST_DUMMY;
      end
    end
  end

  assign tabAddr = {tabLast_q ? `PSQ_LAST_PAGE : pc_q[11:8], tblPtr_q};

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pc_q <= `PSQ_VEC_RESET;
      pmemAddr_q <= `PSQ_VEC_RESET;
      state_q <= ST_DUMMY;
      execValid_q <= 1'b0;
      instrWord_q <= {`PSQ_WORD_W{1'b0}};
      intAck_q <= 3'h0;
    end else begin
      intAck_q <= intTake ? intSel : 3'h0;
      if (endCycle) begin
        pc_q <= pc_d;
        state_q <= state_d;
        // Table cycle addresses the table, all others the counter
        pmemAddr_q <= (state_d == ST_TABLE) ? tabAddr_next(pc_q) : pc_d;
        if (state_q != ST_TABLE) begin
          instrWord_q <= pmemData;
        end
        execValid_q <= (state_d == ST_EXEC);
      end
    end
  end

  // Table address for the cycle that starts now; pointer write in this cycle is seen
  function automatic psq_pc_t tabAddr_next(input psq_pc_t pc);
    logic [7:0] ptr;
    ptr = tblPtr_q;
    if (wrEn && wrAddr == `PSQ_ADDR_TBL_PTR) begin
      ptr = wrData;
    end
    tabAddr_next = {(op == OP_TAB_LAST) ? `PSQ_LAST_PAGE : pc[11:8], ptr};
  endfunction

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tabDest_q <= `PSQ_BYTE_ZERO;
      tabLast_q <= 1'b0;
    end else if (endCycle && (op == OP_TAB_CUR || op == OP_TAB_LAST)) begin
      tabDest_q <= resolveAddr(cmd.tabDest, mp0_q, mp1_q);
      tabLast_q <= (op == OP_TAB_LAST);
    end
  end

  // One write path: table result in the table cycle, otherwise the executing instruction
  always_comb begin
    wrEn = 1'b0;
    wrAddr = daccEff;
    wrData = dacc.wdata;
    if (endCycle && state_q == ST_TABLE) begin
      wrEn = !isIndirect(tabDest_q);
      wrAddr = tabDest_q;
      wrData = pmemData[7:0];
    end else if (endCycle && execValid_q && dacc.wr) begin
      wrEn = !isIndirect(daccEff);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tblHigh_q <= `PSQ_TBL_HIGH_RST;
    end else if (endCycle && state_q == ST_TABLE) begin
      // Unused top bit reads as zero
      tblHigh_q <= {1'b0, pmemData[`PSQ_TBL_HIGH_MSB:`PSQ_TBL_HIGH_LSB]};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tblPtr_q <= `PSQ_TBL_PTR_RST;
      mp0_q <= `PSQ_MP_RST;
      mp1_q <= `PSQ_MP_RST;
    end else if (wrEn) begin
      case (wrAddr)
        `PSQ_ADDR_TBL_PTR: tblPtr_q <= wrData;
        `PSQ_ADDR_MP0: mp0_q <= wrData;
        `PSQ_ADDR_MP1: mp1_q <= wrData;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (wrEn && isRam(wrAddr)) begin
      ram[wrAddr - `PSQ_RAM_BASE] <= wrData;
    end
  end

  // Writes to the table high byte fall through and are dropped
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      extWr_q <= '0;
    end else begin
      extWr_q.wr <= wrEn && isExtSfr(wrAddr);
      extWr_q.addr <= wrAddr;
      extWr_q.wdata <= wrData;
    end
  end

  // Read data follows the address one clock later
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata_q <= `PSQ_BYTE_ZERO;
    end else if (isIndirect(daccEff)) begin
      rdata_q <= `PSQ_BYTE_ZERO;
    end else if (isRam(daccEff)) begin
      rdata_q <= ram[daccEff - `PSQ_RAM_BASE];
    end else if (isExtSfr(daccEff)) begin
      rdata_q <= extRdata;
    end else begin
      case (daccEff)
        `PSQ_ADDR_MP0: rdata_q <= mp0_q;
        `PSQ_ADDR_MP1: rdata_q <= mp1_q;
        `PSQ_ADDR_CNT_LOW: rdata_q <= pc_q[7:0];
        `PSQ_ADDR_TBL_PTR: rdata_q <= tblPtr_q;
        `PSQ_ADDR_TBL_HIGH: rdata_q <= tblHigh_q;
        default: rdata_q <= `PSQ_BYTE_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stackFull_q <= 1'b0;
    end else begin
      stackFull_q <= stackFull;
    end
  end

  psq_return_stack u_stack (
    .clk_sys(clk_sys),
    .rst(rst),
    .push(push && endCycle),
    .pop(pop && !push),
    .pushData(pc_q),
    .top(stackTop),
    .full(stackFull)
  );

endmodule

// ==== pkg/psq_regs.svh ====
// Offsets, field positions, reset values, vectors and timing counts for the program sequencer.
// Assumes inclusion by bare name from the sequencer design files.
`ifndef PSQ_REGS_SVH
`define PSQ_REGS_SVH

`define PSQ_PHASES 2'h3
`define PSQ_PC_W 12
`define PSQ_WORD_W 15
`define PSQ_STACK_DEPTH 3'h6
`define PSQ_STACK_LAST 3'h5
`define PSQ_ADDR_IND0 8'h00
`define PSQ_ADDR_MP0 8'h01
`define PSQ_ADDR_IND1 8'h02
`define PSQ_ADDR_MP1 8'h03
`define PSQ_ADDR_CNT_LOW 8'h06
`define PSQ_ADDR_TBL_PTR 8'h07
`define PSQ_ADDR_TBL_HIGH 8'h08
`define PSQ_RAM_BASE 8'h60
`define PSQ_RAM_WORDS 160
`define PSQ_VEC_RESET 12'h000
`define PSQ_VEC_EXT 12'h004
`define PSQ_VEC_TMR0 12'h008
`define PSQ_VEC_TMR1 12'h00c
`define PSQ_LAST_PAGE 4'hf
`define PSQ_TBL_HIGH_MSB 14
`define PSQ_TBL_HIGH_LSB 8
`define PSQ_BYTE_ZERO 8'h00
`define PSQ_TBL_PTR_RST 8'h00
`define PSQ_TBL_HIGH_RST 8'h00
`define PSQ_MP_RST 8'h00

`endif

// ==== pkg/psq_pkg.sv ====
// Types shared by the program sequencer and its return stack.
// Assumes psq_regs.svh supplies the widths.
`include "psq_regs.svh"

package psq_pkg;

  typedef enum logic [2:0] {
    OP_NONE, OP_JUMP, OP_CALL, OP_RET, OP_RETURN_FROM_INTERRUPT, OP_SKIP, OP_TAB_CUR, OP_TAB_LAST
  } psq_op_e;

  typedef enum logic [1:0] {
    ST_EXEC, ST_DUMMY, ST_TABLE
  } psq_state_e;

  typedef struct packed {
    psq_op_e op;
    logic [`PSQ_PC_W-1:0] target;
    logic [7:0] tabDest;
  } psq_cmd_s;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } psq_dacc_s;

  typedef logic [`PSQ_PC_W-1:0] psq_pc_t;

endpackage

// ==== rtl/psq_return_stack.sv ====
// Six-entry circular return stack; a push when full drops the oldest entry.
// Assumes push and pop are one-clock strobes and never both high.
`timescale 1ns/1ps
`include "psq_regs.svh"

module psq_return_stack (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic push,
  input wire logic pop,
  input wire psq_pkg::psq_pc_t pushData,
  output psq_pkg::psq_pc_t top,
  output logic full
);
  import psq_pkg::*;

  psq_pc_t entry [0:5];
  logic [2:0] idx_q;
  logic [2:0] count_q;

  function automatic logic [2:0] stepIdx(input logic [2:0] i, input logic up);
    if (up) begin
      stepIdx = (i == `PSQ_STACK_LAST) ? 3'h0 : i + 3'h1;
    end else begin
      stepIdx = (i == 3'h0) ? `PSQ_STACK_LAST : i - 3'h1;
    end
  endfunction

  assign top = entry[stepIdx(idx_q, 1'b0)];
  assign full = (count_q == `PSQ_STACK_DEPTH);

  always_ff @(posedge clk_sys) begin
    if (push) begin
      entry[idx_q] <= pushData;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      idx_q <= 3'h0;
      count_q <= 3'h0;
    end else if (push) begin
      idx_q <= stepIdx(idx_q, 1'b1);
      // Oldest slot is reused once all six hold addresses
      count_q <= full ? count_q : count_q + 3'h1;
    end else if (pop) begin
      idx_q <= stepIdx(idx_q, 1'b0);
      count_q <= (count_q == 3'h0) ? count_q : count_q - 3'h1;
    end
  end

endmodule

// ==== verif/psq_prog_mem.sv ====
// Program memory model for the sequencer's fetch and table address.
// Assumes the address is a register and the word is read back at once.
`timescale 1ns/1ps
module psq_prog_mem (
  input wire logic [11:0] addr,
  output logic [14:0] data
);
  // Word encodes its own address so a misrouted fetch shows
  assign data = {3'h5, addr};
endmodule

// ==== verif/psq_sequencer_sva.sv ====
// Port checks for the program sequencer.
// Assumes it is bound onto psq_sequencer and sees only its ports.
`timescale 1ns/1ps
`include "psq_regs.svh"
module psq_sequencer_sva (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [3:0] phase_q,
  input wire psq_pkg::psq_pc_t pmemAddr_q,
  input wire logic [`PSQ_WORD_W-1:0] instrWord_q,
  input wire logic execValid_q,
  input wire psq_pkg::psq_cmd_s cmd,
  input wire psq_pkg::psq_dacc_s dacc,
  input wire logic [2:0] intReq,
  input wire logic [2:0] intAck_q,
  input wire logic stackFull_q
);
  import psq_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic cycEnd, plain;
  logic [3:0] rot;
  psq_pc_t vecExp;
  assign cycEnd = phase_q[3] & execValid_q;
  assign plain = cmd.op == OP_NONE && !dacc.wr;
  assign rot = {phase_q[2:0], phase_q[3]};
  assign vecExp = intReq[0] ? `PSQ_VEC_EXT : intReq[1] ? `PSQ_VEC_TMR0 : `PSQ_VEC_TMR1;

  AST_PHASE_ROT: assert property (!$past(rst) |-> phase_q == $past(rot))
    else $error("phase did not rotate");
  AST_CYCLE_STEADY: assert property (!phase_q[0] |-> $stable(pmemAddr_q) && $stable(execValid_q))
    else $error("fetch state moved mid cycle");
  AST_SEQ_INC: assert property (cycEnd && plain && intReq == 3'h0
    |=> pmemAddr_q == $past(pmemAddr_q) + 12'h1) else $error("counter did not step");
  AST_JUMP_LOAD: assert property (cycEnd && cmd.op inside {OP_JUMP, OP_CALL}
    |=> pmemAddr_q == $past(cmd.target) && !execValid_q) else $error("jump target lost");
  AST_SKIP: assert property (cycEnd && cmd.op == OP_SKIP
    |=> pmemAddr_q == $past(pmemAddr_q) + 12'h1 && !execValid_q) else $error("skip wrong");
  AST_SHORT_JUMP: assert property (cycEnd && cmd.op == OP_NONE && dacc.wr
    && dacc.addr == `PSQ_ADDR_CNT_LOW
    |=> pmemAddr_q == {$past(pmemAddr_q[11:8]), $past(dacc.wdata)}) else $error("short jump");
  AST_INT_VECTOR: assert property (cycEnd && plain && intReq != 3'h0 && !stackFull_q
    |=> pmemAddr_q == $past(vecExp) ##[0:1] $onehot(intAck_q)) else $error("bad vector");
  AST_FULL_WAIT: assert property (cycEnd && plain && stackFull_q && intReq != 3'h0
    |=> pmemAddr_q == $past(pmemAddr_q) + 12'h1 && intAck_q == 3'h0) else $error("full ack");
  AST_ACK_PULSE: assert property (intAck_q != 3'h0 |=> intAck_q == 3'h0)
    else $error("ack longer than a clock");
  AST_RESET_CLEAR: assert property (disable iff (1'b0) rst
    |=> pmemAddr_q == `PSQ_VEC_RESET && !execValid_q) else $error("reset state wrong");

  cover property (cycEnd && cmd.op == OP_CALL);
  cover property (intAck_q != 3'h0);
  cover property (cycEnd && cmd.op == OP_TAB_LAST);
endmodule

bind psq_sequencer psq_sequencer_sva i_psq_sequencer_sva (
  .clk_sys(clk_sys), .rst(rst), .phase_q(phase_q), .pmemAddr_q(pmemAddr_q),
  .instrWord_q(instrWord_q), .execValid_q(execValid_q), .cmd(cmd), .dacc(dacc),
  .intReq(intReq), .intAck_q(intAck_q), .stackFull_q(stackFull_q));

// ==== verif/tb_top.sv ====
// Bench for the program sequencer; it plays decoder, data side and interrupt owner.
// Assumes psq_prog_mem holds each word as a fixed function of its address.
`timescale 1ns/1ps
`include "psq_regs.svh"
module tb_top;
  import psq_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [3:0] phase_q, pg;
  psq_pc_t pmemAddr_q, cur, rt;
  psq_pc_t rs [7];
  logic [14:0] pmemData, instrWord_q;
  logic execValid_q, stackFull_q;
  logic [7:0] rdata_q;
  logic [2:0] intReq, intAck_q;
  psq_cmd_s cmd;
  psq_dacc_s dacc;
  int mismatches = 0;
  int num_checks = 0;

  always #5 clk_sys = ~clk_sys;

  psq_prog_mem i_psq_prog_mem (.addr(pmemAddr_q), .data(pmemData));
  psq_sequencer i_psq_sequencer (
    .clk_sys(clk_sys), .rst(rst), .phase_q(phase_q), .pmemAddr_q(pmemAddr_q),
    .pmemData(pmemData), .instrWord_q(instrWord_q), .execValid_q(execValid_q), .cmd(cmd),
    .dacc(dacc), .rdata_q(rdata_q), .extRdata(8'h3c), .extWr_q(), .intReq(intReq),
    .intAck_q(intAck_q), .stackFull_q(stackFull_q));

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic guard(inout int n);
    n++;
    if (n > 500) begin
      mismatches++;
      $display("unexpected at %0t: wait ran out", $time);
      tally_and_finish();
    end
  endtask

  // Parks on the falling edge inside phase 3 of an executing cycle
  task automatic wait_exec();
    int n = 0;
    while (!(phase_q[3] === 1'b1 && execValid_q === 1'b1)) begin
      @(negedge clk_sys);
      guard(n);
    end
  endtask

  task automatic landed(input psq_pc_t a);
    @(negedge clk_sys);
    wait_exec();
    check(instrWord_q, {3'h5, a});
    check(pmemAddr_q, a + 12'h1);
    cur = a;
  endtask

  task automatic issue(input psq_op_e op, input psq_pc_t t, input logic w,
                       input logic [7:0] a, input logic [7:0] d);
    wait_exec();
    cmd = '{op, t, a};
    dacc = '{w, a, d};
    @(negedge clk_sys);
    cmd.op = OP_NONE;
    dacc.wr = 1'b0;
  endtask

  task automatic go(input psq_op_e op, input psq_pc_t t, input logic w,
                    input logic [7:0] a, input logic [7:0] d, input psq_pc_t nxt);
    issue(op, t, w, a, d);
    landed(nxt);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_sys);
    dacc.addr = a;
    @(negedge clk_sys);
    check(rdata_q, exp);
    // Reads use up clocks, so pick up the word now executing
    wait_exec();
    cur = pmemAddr_q - 12'h1;
  endtask

  task automatic ack(input int i);
    int n = 0;
    while (intAck_q === 3'h0) begin
      @(negedge clk_sys);
      guard(n);
    end
    check(intAck_q, 3'h1 << i);
    intReq = 3'h0;
  endtask

  initial begin
    cmd = '{OP_NONE, 12'h000, 8'h00};
    dacc = '{1'b0, 8'h00, 8'h00};
    intReq = 3'h0;
    repeat (6) @(negedge clk_sys);
    check(pmemAddr_q, 16'h0000);
    rst = 1'b0;
    landed(12'h000);
    go(OP_JUMP, 12'h123, 1'b0, 8'h00, 8'h00, 12'h123);
    go(OP_SKIP, 12'h000, 1'b0, 8'h00, 8'h00, 12'h125);
    go(OP_NONE, 12'h000, 1'b1, 8'h06, 8'h40, 12'h140);
    $display("test flow done");
    go(OP_NONE, 12'h000, 1'b1, 8'h07, 8'h5a, 12'h141);
    rd(8'h07, 8'h5a);
    for (int j = 0; j < 2; j++) begin
      pg = j ? 4'hf : cur[11:8];
      go(j ? OP_TAB_LAST : OP_TAB_CUR, 12'h000, 1'b0, 8'h70, 8'h00, cur + 12'h1);
      rd(8'h70, 8'h5a);
      rd(8'h08, {4'h5, pg});
    end
    go(OP_NONE, 12'h000, 1'b1, 8'h08, 8'h33, cur + 12'h1);
    rd(8'h08, 8'h5f);
    $display("test table done");
    go(OP_NONE, 12'h000, 1'b1, 8'hff, 8'ha7, cur + 12'h1);
    rd(8'hff, 8'ha7);
    rd(8'h20, 8'h00);
    rd(8'h05, 8'h3c);
    go(OP_NONE, 12'h000, 1'b1, 8'h01, 8'h61, cur + 12'h1);
    go(OP_NONE, 12'h000, 1'b1, 8'h00, 8'hc3, cur + 12'h1);
    rd(8'h61, 8'hc3);
    go(OP_NONE, 12'h000, 1'b1, 8'h03, 8'h02, cur + 12'h1);
    rd(8'h02, 8'h00);
    $display("test data done");
    for (int i = 0; i < 3; i++) begin
      wait_exec();
      rt = pmemAddr_q;
      intReq = 3'h1 << i;
      ack(i);
      landed(12'(4 * (i + 1)));
      go(OP_RETURN_FROM_INTERRUPT, 12'h000, 1'b0, 8'h00, 8'h00, rt);
    end
    $display("test interrupt done");
    for (int i = 0; i < 7; i++) begin
      wait_exec();
      rs[i] = pmemAddr_q;
      go(OP_CALL, 12'h200 + 12'(i * 16), 1'b0, 8'h00, 8'h00, 12'h200 + 12'(i * 16));
      check(stackFull_q, i > 4);
    end
    intReq = 3'h2;
    go(OP_NONE, 12'h000, 1'b0, 8'h00, 8'h00, cur + 12'h1);
    check(intAck_q, 3'h0);
    issue(OP_RET, 12'h000, 1'b0, 8'h00, 8'h00);
    ack(1);
    landed(12'h008);
    issue(OP_RETURN_FROM_INTERRUPT, 12'h000, 1'b0, 8'h00, 8'h00);
    for (int k = 5; k > 0; k--) go(OP_RET, 12'h000, 1'b0, 8'h00, 8'h00, rs[k]);
    $display("test stack done");
    tally_and_finish();
  end
endmodule
